// *** hdl/cdr_comparator_dac_reference_control.sv ***
`timescale 1ns/10ps
// What this block does
// - External select picks external DAC reference
// - Hysteresis edge bit: one falling, zero rising
// - State bit reads comparator after polarity
// - Gain bit: 1.8x when set, 1.0x clear
// - Invert bit flips comparator output downstream
// - Range bit, external select clear: half supply high, internal low
// - DAC register holds 10-bit reference code
// - Upper six code bits read zero
// - Control bits clear at reset, comparator output held low only while reset is asserted
module cdr_comparator_dac_reference_control (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // Analog side
  input wire logic comparator_raw,
  output cdr_pkg::cdr_analog_cfg_t analog_cfg,
  output logic comparator_out
);
  import cdr_pkg::*;

  logic [15:0] control_q;
  logic [15:0] control_d;
  logic [15:0] code_q;
  logic [15:0] code_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic state_q;
  logic state_d;
  cdr_analog_cfg_t cfg_q;
  cdr_analog_cfg_t cfg_d;
  logic polarized;

  assign polarized = comparator_raw ^ control_q[CDR_BIT_INVERT];

  always_comb begin
    control_d = control_q;
    code_d = code_q;
    rdata_d = 16'h0000;
    state_d = polarized;
    if (reg_write) begin
      if (reg_addr == CDR_ADDR_CONTROL) begin
        control_d = reg_wdata & CDR_CONTROL_WMASK;
      end else if (reg_addr == CDR_ADDR_DAC_CODE) begin
        code_d = reg_wdata & CDR_CODE_WMASK;
      end
    end
    if (reg_read) begin
      case (reg_addr)
        CDR_ADDR_CONTROL: begin
          rdata_d = control_q;
          rdata_d[CDR_BIT_STATE] = state_q;
        end
        CDR_ADDR_DAC_CODE: begin
          rdata_d = code_q & CDR_CODE_WMASK;
        end
        default: begin
          rdata_d = 16'h0000;
        end
      endcase
    end
  end

  always_comb begin
    cfg_d = '0;
    if (control_d[CDR_BIT_EXT_REF]) begin
      cfg_d.ref_src = CDR_REF_EXTERNAL;
    end else if (control_d[CDR_BIT_RANGE]) begin
      cfg_d.ref_src = CDR_REF_HALF_SUPPLY;
    end else begin
      cfg_d.ref_src = CDR_REF_INTERNAL;
    end
    cfg_d.hysteresis_edge_select = control_d[CDR_BIT_HYS_EDGE];
    cfg_d.dac_gain_select = control_d[CDR_BIT_GAIN];
    cfg_d.output_invert = control_d[CDR_BIT_INVERT];
    // software keeps this unique across comparators
    cfg_d.dac_pin_output_enable = control_d[CDR_BIT_DAC_PIN_OE];
    cfg_d.dac_reference_code = code_d[CDR_CODE_WIDTH-1:0];
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      control_q <= CDR_CONTROL_RESET;
      code_q <= CDR_CODE_RESET;
      rdata_q <= 16'h0000;
      state_q <= 1'b0;
      cfg_q <= '0;
    end else begin
      control_q <= control_d;
      code_q <= code_d;
      rdata_q <= rdata_d;
      state_q <= state_d;
      cfg_q <= cfg_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign analog_cfg = cfg_q;
  assign comparator_out = state_q;

  property p_code_upper_zero;
    @(posedge core_clk) disable iff (!reset_n)
      reg_read && reg_addr == CDR_ADDR_DAC_CODE |=> reg_rdata[15:10] == 6'h00;
  endproperty
  a_code_upper_zero: assert property (p_code_upper_zero)
    else $error("DAC code upper bits not zero");

  property p_code_write;
    @(posedge core_clk) disable iff (!reset_n)
      reg_write && reg_addr == CDR_ADDR_DAC_CODE |=>
        analog_cfg.dac_reference_code == $past(reg_wdata[9:0]);
  endproperty
  a_code_write: assert property (p_code_write)
    else $error("DAC code not applied next edge");

  property p_ext_ref;
    @(posedge core_clk) disable iff (!reset_n)
      reg_write && reg_addr == CDR_ADDR_CONTROL && reg_wdata[5] |=>
        analog_cfg.ref_src == CDR_REF_EXTERNAL;
  endproperty
  a_ext_ref: assert property (p_ext_ref)
    else $error("External reference not selected");

  property p_range;
    @(posedge core_clk) disable iff (!reset_n)
      reg_write && reg_addr == CDR_ADDR_CONTROL && !reg_wdata[5] |=>
        analog_cfg.ref_src == ($past(reg_wdata[0]) ? CDR_REF_HALF_SUPPLY : CDR_REF_INTERNAL);
  endproperty
  a_range: assert property (p_range)
    else $error("Internal range selection wrong");

  property p_hys_edge;
    @(posedge core_clk) disable iff (!reset_n)
      reg_write && reg_addr == CDR_ADDR_CONTROL |=>
        analog_cfg.hysteresis_edge_select == $past(reg_wdata[4]);
  endproperty
  a_hys_edge: assert property (p_hys_edge)
    else $error("Hysteresis edge not applied");

  property p_gain;
    @(posedge core_clk) disable iff (!reset_n)
      reg_write && reg_addr == CDR_ADDR_CONTROL |=>
        analog_cfg.dac_gain_select == $past(reg_wdata[2]);
  endproperty
  a_gain: assert property (p_gain)
    else $error("Gain select not applied");

  property p_invert;
    @(posedge core_clk) disable iff (!reset_n)
      1'b1 |=> comparator_out == ($past(comparator_raw) ^ $past(control_q[1]));
  endproperty
  a_invert: assert property (p_invert)
    else $error("Comparator polarity wrong");

  property p_state_read;
    @(posedge core_clk) disable iff (!reset_n)
      reg_read && reg_addr == CDR_ADDR_CONTROL |=> reg_rdata[3] == $past(comparator_out);
  endproperty
  a_state_read: assert property (p_state_read)
    else $error("State bit does not match comparator");

  property p_reset_clear;
    @(posedge core_clk)
      !reset_n |=> analog_cfg == '0 && reg_rdata == 16'h0000;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("Outputs not cleared by reset");

  property p_write_next_edge;
    @(posedge core_clk) disable iff (!reset_n)
      reg_write && reg_addr == CDR_ADDR_CONTROL |=>
        analog_cfg.dac_pin_output_enable == $past(reg_wdata[8]) &&
        analog_cfg.output_invert == $past(reg_wdata[1]);
  endproperty
  a_write_next_edge: assert property (p_write_next_edge)
    else $error("Control write not applied next edge");

  property p_rdata_idle;
    @(posedge core_clk) disable iff (!reset_n)
      !reg_read |=> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("Read data not cleared after one cycle");

  property p_unmapped_read;
    @(posedge core_clk) disable iff (!reset_n)
      reg_read && reg_addr[1] |=> reg_rdata == 16'h0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("Unmapped read not zero");

  property p_ctrl_read_mask;
    @(posedge core_clk) disable iff (!reset_n)
      reg_read && reg_addr == CDR_ADDR_CONTROL |=>
        (reg_rdata & ~(CDR_CONTROL_WMASK | 16'h0008)) == 16'h0000;
  endproperty
  a_ctrl_read_mask: assert property (p_ctrl_read_mask)
    else $error("Unimplemented control bits read nonzero");

  property p_cfg_hold;
    @(posedge core_clk) disable iff (!reset_n)
      !reg_write |=> $stable(analog_cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("Config changed without a write");

  property p_unmapped_write;
    @(posedge core_clk) disable iff (!reset_n)
      reg_write && reg_addr[1] |=> $stable(analog_cfg);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("Unmapped write changed config");

  property p_ref_src_legal;
    @(posedge core_clk) disable iff (!reset_n)
      analog_cfg.ref_src != 2'h3;
  endproperty
  a_ref_src_legal: assert property (p_ref_src_legal)
    else $error("Reference source code undefined");

  property p_code_hold;
    @(posedge core_clk) disable iff (!reset_n)
      reg_write && reg_addr != CDR_ADDR_DAC_CODE |=>
        $stable(analog_cfg.dac_reference_code);
  endproperty
  a_code_hold: assert property (p_code_hold)
    else $error("DAC code changed by other write");

  property p_code_read;
    @(posedge core_clk) disable iff (!reset_n)
      reg_read && reg_addr == CDR_ADDR_DAC_CODE |=>
        reg_rdata[9:0] == analog_cfg.dac_reference_code;
  endproperty
  a_code_read: assert property (p_code_read)
    else $error("DAC code readback differs from DAC");

  property p_ctrl_read_cfg;
    @(posedge core_clk) disable iff (!reset_n)
      reg_read && reg_addr == CDR_ADDR_CONTROL |=>
        reg_rdata[8] == analog_cfg.dac_pin_output_enable &&
        reg_rdata[4] == analog_cfg.hysteresis_edge_select &&
        reg_rdata[2] == analog_cfg.dac_gain_select;
  endproperty
  a_ctrl_read_cfg: assert property (p_ctrl_read_cfg)
    else $error("Control readback differs from config");

  property p_invert_read;
    @(posedge core_clk) disable iff (!reset_n)
      reg_read && reg_addr == CDR_ADDR_CONTROL |=>
        reg_rdata[1] == analog_cfg.output_invert;
  endproperty
  a_invert_read: assert property (p_invert_read)
    else $error("Invert readback differs from config");

  property p_ext_read;
    @(posedge core_clk) disable iff (!reset_n)
      reg_read && reg_addr == CDR_ADDR_CONTROL |=>
        reg_rdata[5] == (analog_cfg.ref_src == CDR_REF_EXTERNAL);
  endproperty
  a_ext_read: assert property (p_ext_read)
    else $error("External select readback wrong");

  property p_range_read;
    @(posedge core_clk) disable iff (!reset_n)
      reg_read && reg_addr == CDR_ADDR_CONTROL |=>
        (analog_cfg.ref_src == CDR_REF_HALF_SUPPLY) == (reg_rdata[0] && !reg_rdata[5]);
  endproperty
  a_range_read: assert property (p_range_read)
    else $error("Range readback wrong");

  property p_reset_out;
    @(posedge core_clk)
      !reset_n |=> comparator_out == 1'b0;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("Comparator output not cleared by reset");

endmodule : cdr_comparator_dac_reference_control

// *** hdl/cdr_pkg.sv ***
package cdr_pkg;

  // Register indices on the plain register port
  localparam logic [1:0] CDR_ADDR_CONTROL = 2'h0;
  localparam logic [1:0] CDR_ADDR_DAC_CODE = 2'h1;

  // Control register field positions
  localparam int CDR_BIT_DAC_PIN_OE = 8;
  localparam int CDR_BIT_EXT_REF = 5;
  localparam int CDR_BIT_HYS_EDGE = 4;
  localparam int CDR_BIT_STATE = 3;
  localparam int CDR_BIT_GAIN = 2;
  localparam int CDR_BIT_INVERT = 1;
  localparam int CDR_BIT_RANGE = 0;

  // Writable bits of the lower control byte plus output enable; state bit is read only
  localparam logic [15:0] CDR_CONTROL_WMASK = 16'h0137;
  localparam logic [15:0] CDR_CONTROL_RESET = 16'h0000;

  // Reference code layout
  localparam int CDR_CODE_WIDTH = 10;
  localparam logic [15:0] CDR_CODE_WMASK = 16'h03ff;
  localparam logic [15:0] CDR_CODE_RESET = 16'h0000;
  localparam int CDR_CODE_FULL_SCALE = 1024;

  // Reference source encoding driven to the analog mux
  typedef enum logic [1:0] {
    CDR_REF_INTERNAL = 2'h0,
    CDR_REF_HALF_SUPPLY = 2'h1,
    CDR_REF_EXTERNAL = 2'h2
  } cdr_ref_src_t;

  // Configuration bundle to the analog comparator and DAC
  typedef struct packed {
    logic dac_pin_output_enable;
    cdr_ref_src_t ref_src;
    logic hysteresis_edge_select;
    logic dac_gain_select;
    logic output_invert;
    logic [CDR_CODE_WIDTH-1:0] dac_reference_code;
  } cdr_analog_cfg_t;

endpackage : cdr_pkg

// *** sim/cdr_comparator_dac_reference_control_tb.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module cdr_comparator_dac_reference_control_tb;
  import cdr_pkg::*;
  logic core_clk;
  logic reset_n;
  logic [1:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [15:0] reg_rdata;
  logic comparator_raw;
  cdr_analog_cfg_t analog_cfg;
  logic comparator_out;
  int n_mismatch = 0;
  int check_count = 0;

  cdr_comparator_dac_reference_control u_dut (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .comparator_raw(comparator_raw),
    .analog_cfg(analog_cfg),
    .comparator_out(comparator_out)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // Strobe launched at an edge; result sampled just after the taking edge
  task wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task rd(input logic [1:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : rd

  task tick;
    @(posedge core_clk);
    #1;
  endtask : tick

  initial begin
    reset_n = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    comparator_raw = 1'b0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    tick();
    `CHK(analog_cfg, 16'h0000)
    rd(CDR_ADDR_CONTROL, 16'h0000);
    wr(CDR_ADDR_DAC_CODE, 16'hffff);
    `CHK(analog_cfg.dac_reference_code, 10'h3ff)
    rd(CDR_ADDR_DAC_CODE, 16'h03ff);
    // Only this comparator ever drives the DAC pin
    wr(CDR_ADDR_CONTROL, 16'hffff);
    `CHK(analog_cfg.ref_src, CDR_REF_EXTERNAL)
    `CHK({analog_cfg.hysteresis_edge_select, analog_cfg.dac_gain_select}, 2'h3)
    `CHK({analog_cfg.output_invert, analog_cfg.dac_pin_output_enable}, 2'h3)
    // Raw low, inverted, so the live state bit reads one
    rd(CDR_ADDR_CONTROL, 16'h013f);
    wr(CDR_ADDR_CONTROL, 16'h0001);
    `CHK(analog_cfg.ref_src, CDR_REF_HALF_SUPPLY)
    `CHK({analog_cfg.hysteresis_edge_select, analog_cfg.dac_gain_select}, 2'h0)
    `CHK(analog_cfg.dac_pin_output_enable, 1'b0)
    wr(CDR_ADDR_CONTROL, 16'h0000);
    `CHK(analog_cfg.ref_src, CDR_REF_INTERNAL)
    @(posedge core_clk);
    comparator_raw <= 1'b1;
    tick();
    `CHK(comparator_out, 1'b1)
    rd(CDR_ADDR_CONTROL, 16'h0008);
    wr(CDR_ADDR_CONTROL, 16'h0002);
    tick();
    `CHK(comparator_out, 1'b0)
    rd(CDR_ADDR_CONTROL, 16'h0002);
    wr(2'h2, 16'hffff);
    rd(2'h2, 16'h0000);
    rd(CDR_ADDR_DAC_CODE, 16'h03ff);
    wr(CDR_ADDR_DAC_CODE, 16'hfd55);
    rd(CDR_ADDR_DAC_CODE, 16'h0155);
    // Second reset in mid-run with config loaded
    @(posedge core_clk);
    comparator_raw <= 1'b0;
    reset_n <= 1'b0;
    @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    `CHK(analog_cfg, 16'h0000)
    `CHK(comparator_out, 1'b0)
    tick();
    rd(CDR_ADDR_DAC_CODE, 16'h0000);
    tally_and_finish();
  end

  // Tests need well under a microsecond
  initial begin
    #5000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : cdr_comparator_dac_reference_control_tb
